//--- hw/tas_core.sv
/*
  Trigger sequencing, trigger delay, averaging and running statistics.
  Assumes key and isolated trigger pins are asynchronous and active low,
  the sample front end answers each meas_start with one sample_valid, and
  all other inputs come from logic on core_clk.
*/
`timescale 1ns/1ns
module tas_core
  import tas_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TAS_MS_CYCLES
)
(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               trig_source_ext,
  input  wire logic               continuous_en,
  input  wire logic               key_trig_n,
  input  wire logic               iso_trig_n,
  input  wire logic               host_trig,
  input  wire logic [13:0]        delay_ms,
  input  wire logic               avg_en,
  input  wire logic [4:0]         avg_count,
  input  wire logic               sample_valid,
  input  wire logic signed [23:0] sample_data,
  input  wire logic               stat_en,
  input  wire logic               stat_clear,
  input  wire logic               auto_clear_print,
  input  wire logic               settings_changed,
  input  wire logic               print_req,
  input  wire logic               print_done,
  input  wire logic signed [23:0] thr_hi,
  input  wire logic signed [23:0] thr_lo,
  output logic                    external_source_indicator,
  output logic                    meas_start,
  output logic                    result_valid,
  output logic signed [23:0]      result_data,
  output logic [14:0]             stat_count,
  output logic signed [23:0]      stat_mean,
  output logic signed [23:0]      stat_max,
  output logic signed [23:0]      stat_min,
  output logic [31:0]             stat_sd_pop,
  output logic [31:0]             stat_sd_samp,
  output logic [15:0]             stat_cp,
  output logic [15:0]             stat_cpk,
  output logic                    stat_sd_samp_valid,
  output logic                    stat_cp_valid,
  output logic                    print_start
);

  // Input synchronisers and edge detection
  logic [1:0] key_sync;
  logic [1:0] iso_sync;
  logic       key_prev;
  logic       iso_prev;
  logic       key_fall;
  logic       iso_fall;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      key_sync <= TAS_SYNC_RST;
      iso_sync <= TAS_SYNC_RST;
      key_prev <= 1'b1;
      iso_prev <= 1'b1;
    end else begin
      key_sync <= {key_sync[0], key_trig_n};
      iso_sync <= {iso_sync[0], iso_trig_n};
      key_prev <= key_sync[1];
      iso_prev <= iso_sync[1];
    end
  end

  assign key_fall = key_prev & ~key_sync[1];
  assign iso_fall = iso_prev & ~iso_sync[1];

  // Trigger decision
  logic        any_evt;
  logic        meas_trig;
  logic        grab_evt;
  logic [13:0] delay_eff;
  logic [4:0]  n_avg;

  assign any_evt   = key_fall | iso_fall | host_trig;
  assign meas_trig = trig_source_ext ? any_evt
                   : (continuous_en ? 1'b1
                   : host_trig);
  assign grab_evt  = ~trig_source_ext & stat_en & any_evt;
  assign delay_eff = (delay_ms > TAS_DELAY_MAX) ? TAS_DELAY_MAX : delay_ms;
  assign n_avg     = ~avg_en ? TAS_AVG_OFF
                   : (avg_count < TAS_AVG_MIN) ? TAS_AVG_MIN
                   : (avg_count > TAS_AVG_MAX) ? TAS_AVG_MAX : avg_count;

  function automatic logic signed [23:0] tas_avg(input logic signed [28:0] s,
                                                  input logic [4:0] n);
    logic [28:0]        mag;
    logic [31:0]        r;
    logic [63:0]        prod;
    logic signed [23:0] q;
    mag = s[28] ? 29'(-s) : 29'(s);
    r   = '0;
    for (int k = 2; k <= 16; k++) begin
      if (n == 5'(k)) begin
        r = 32'((64'h1_0000_0000 + 64'(k) - 64'h1) / 64'(k));
      end
    end
    prod = 64'(mag) * 64'(r);
    q    = (n == TAS_AVG_OFF) ? s[23:0] : prod[55:32];
    if (s[28] && n != TAS_AVG_OFF) begin
      q = -q;
    end
    return q;
  endfunction : tas_avg

  // Measurement sequencing
  tas_meas_e                mstate;
  tas_meas_e                next_mstate;
  logic [31:0]              ms_cnt;
  logic [31:0]              next_ms_cnt;
  logic [13:0]              ms_left;
  logic [13:0]              next_ms_left;
  logic signed [28:0]       avg_sum;
  logic signed [28:0]       next_avg_sum;
  logic [4:0]               avg_left;
  logic [4:0]               next_avg_left;
  logic [4:0]               avg_n;
  logic [4:0]               next_avg_n;
  logic                     grab_pending;
  logic                     next_grab_pending;
  logic                     next_meas_start;
  logic                     next_result_valid;
  logic signed [23:0]       next_result_data;
  logic                     next_ext_ind;

  always_comb begin
    logic signed [28:0] sum_now;
    sum_now           = avg_sum + 29'(sample_data);
    next_mstate       = mstate;
    next_ms_cnt       = ms_cnt;
    next_ms_left      = ms_left;
    next_avg_sum      = avg_sum;
    next_avg_left     = avg_left;
    next_avg_n        = avg_n;
    next_meas_start   = 1'b0;
    next_result_valid = 1'b0;
    next_result_data  = result_data;
    next_ext_ind      = trig_source_ext;
    next_grab_pending = (grab_pending & ~result_valid) | grab_evt;
    case (mstate)
      TAS_M_IDLE: begin
        if (meas_trig) begin
          next_avg_sum  = '0;
          next_avg_left = n_avg;
          next_avg_n    = n_avg;
          next_ms_cnt   = '0;
          if (delay_eff == '0) begin
            next_meas_start = 1'b1;
            next_mstate     = TAS_M_SAMPLE;
          end else begin
            next_ms_left = delay_eff;
            next_mstate  = TAS_M_DELAY;
          end
        end
      end
      TAS_M_DELAY: begin
        if (ms_cnt == 32'(MS_CYCLES - 1)) begin
          next_ms_cnt  = '0;
          next_ms_left = ms_left - 14'h0001;
          if (ms_left == 14'h0001) begin
            next_meas_start = 1'b1;
            next_mstate     = TAS_M_SAMPLE;
          end
        end else begin
          next_ms_cnt = ms_cnt + 32'h0000_0001;
        end
      end
      TAS_M_SAMPLE: begin
        if (sample_valid) begin
          next_avg_sum  = sum_now;
          next_avg_left = avg_left - 5'h01;
          if (avg_left == 5'h01) begin
            next_result_valid = 1'b1;
            next_result_data  = tas_avg(sum_now, avg_n);
            next_mstate       = TAS_M_IDLE;
          end else begin
            next_meas_start = 1'b1;
          end
        end
      end
      default: next_mstate = TAS_M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mstate                    <= TAS_M_IDLE;
      ms_cnt                    <= '0;
      ms_left                   <= '0;
      avg_sum                   <= '0;
      avg_left                  <= '0;
      avg_n                     <= TAS_AVG_OFF;
      grab_pending              <= 1'b0;
      meas_start                <= 1'b0;
      result_valid              <= 1'b0;
      result_data               <= '0;
      external_source_indicator <= 1'b0;
    end else begin
      mstate                    <= next_mstate;
      ms_cnt                    <= next_ms_cnt;
      ms_left                   <= next_ms_left;
      avg_sum                   <= next_avg_sum;
      avg_left                  <= next_avg_left;
      avg_n                     <= next_avg_n;
      grab_pending              <= next_grab_pending;
      meas_start                <= next_meas_start;
      result_valid              <= next_result_valid;
      result_data               <= next_result_data;
      external_source_indicator <= next_ext_ind;
    end
  end

  // Statistics accumulation
  logic               add_req;
  logic               do_clear;
  logic               calc_take;
  logic signed [39:0] sum;
  logic signed [39:0] next_sum;
  logic [63:0]        sumsq;
  logic [63:0]        next_sumsq;
  logic [14:0]        next_count;
  logic signed [23:0] next_max;
  logic signed [23:0] next_min;
  logic               dirty;
  logic               next_dirty;
  logic               calc_req;
  logic               next_calc_req;
  logic               next_sd_valid;
  logic               next_cp_valid;
  logic               next_print_start;

  assign add_req  = result_valid & stat_en & (trig_source_ext | grab_pending);
  assign do_clear = stat_clear | (print_done & auto_clear_print);

  always_comb begin
    logic [23:0] x_abs;
    logic        room;
    x_abs      = result_data[23] ? 24'(-result_data) : 24'(result_data);
    next_sum   = do_clear ? '0 : sum;
    next_sumsq = do_clear ? '0 : sumsq;
    next_count = do_clear ? '0 : stat_count;
    next_max   = stat_max;
    next_min   = stat_min;
    room       = (next_count < TAS_STAT_MAX_N);
    if (add_req && room) begin
      next_sum   = next_sum + 40'(result_data);
      next_sumsq = next_sumsq + 64'(x_abs * x_abs);
      if (next_count == '0 || result_data > stat_max) begin
        next_max = result_data;
      end
      if (next_count == '0 || result_data < stat_min) begin
        next_min = result_data;
      end
      next_count = next_count + 15'h0001;
    end
    next_dirty       = (dirty & ~do_clear) | (settings_changed & stat_en);
    next_calc_req    = (calc_req & ~calc_take) | (add_req & room);
    next_sd_valid    = (next_count > 15'h0001);
    next_cp_valid    = (next_count > 15'h0001) & ~next_dirty;
    next_print_start = print_req & stat_en;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sum                <= '0;
      sumsq              <= '0;
      stat_count         <= '0;
      stat_max           <= '0;
      stat_min           <= '0;
      dirty              <= 1'b0;
      calc_req           <= 1'b0;
      stat_sd_samp_valid <= 1'b0;
      stat_cp_valid      <= 1'b0;
      print_start        <= 1'b0;
    end else begin
      sum                <= next_sum;
      sumsq              <= next_sumsq;
      stat_count         <= next_count;
      stat_max           <= next_max;
      stat_min           <= next_min;
      dirty              <= next_dirty;
      calc_req           <= next_calc_req;
      stat_sd_samp_valid <= next_sd_valid;
      stat_cp_valid      <= next_cp_valid;
      print_start        <= next_print_start;
    end
  end

  // Statistics calculation through the shared arithmetic engine
  tas_calc_e   cstate;
  tas_calc_e   next_cstate;
  logic [2:0]  op;
  logic [2:0]  next_op;
  logic        ar_start;
  logic        next_ar_start;
  logic        ar_sqrt;
  logic [63:0] ar_a;
  logic [39:0] ar_b;
  logic        ar_done;
  logic [63:0] ar_q;
  logic [63:0] var_pop;
  logic [63:0] next_var_pop;
  logic [63:0] var_samp;
  logic [63:0] next_var_samp;
  logic signed [23:0] next_mean;
  logic [31:0] next_sd_pop;
  logic [31:0] next_sd_samp;
  logic [15:0] next_cp;
  logic [15:0] next_cpk;

  assign calc_take = (cstate == TAS_C_IDLE) & calc_req;

  always_comb begin
    logic [39:0]        sum_abs;
    logic [23:0]        mean_abs;
    logic [63:0]        nm;
    logic [63:0]        dev;
    logic [24:0]        span;
    logic signed [26:0] bias;
    logic signed [26:0] cpk_num;
    logic [15:0]        q_clamp;
    sum_abs  = sum[39] ? 40'(-sum) : 40'(sum);
    mean_abs = stat_mean[23] ? 24'(-stat_mean) : 24'(stat_mean);
    nm       = 64'(64'(mean_abs) * 64'(mean_abs) * 64'(stat_count));
    dev      = (sumsq > nm) ? sumsq - nm : '0;
    span     = (thr_hi > thr_lo) ? 25'(thr_hi - thr_lo) : 25'(thr_lo - thr_hi);
    bias     = 27'(thr_hi) + 27'(thr_lo) - 27'(stat_mean) - 27'(stat_mean);
    bias     = bias[26] ? -bias : bias;
    cpk_num  = 27'(span) - bias;
    cpk_num  = cpk_num[26] ? '0 : cpk_num;
    q_clamp  = (ar_q > 64'(TAS_CP_MAX)) ? TAS_CP_MAX : ar_q[15:0];
    ar_sqrt  = (op == 3'h3) || (op == 3'h4);
    case (op)
      3'h0:    ar_a = 64'(sum_abs);
      3'h1:    ar_a = dev;
      3'h2:    ar_a = dev;
      3'h3:    ar_a = var_pop;
      3'h4:    ar_a = var_samp;
      3'h5:    ar_a = 64'(span) * 64'(TAS_CP_SCALE);
      default: ar_a = 64'(cpk_num) * 64'(TAS_CP_SCALE);
    endcase
    case (op)
      3'h0, 3'h1: ar_b = 40'(stat_count);
      3'h2:       ar_b = 40'(stat_count - 15'h0001);
      default:    ar_b = 40'(stat_sd_samp) * 40'(TAS_SIX);
    endcase
    next_cstate   = cstate;
    next_op       = op;
    next_ar_start = 1'b0;
    next_var_pop  = var_pop;
    next_var_samp = var_samp;
    next_mean     = stat_mean;
    next_sd_pop   = stat_sd_pop;
    next_sd_samp  = stat_sd_samp;
    next_cp       = stat_cp;
    next_cpk      = stat_cpk;
    case (cstate)
      TAS_C_IDLE: begin
        if (calc_req) begin
          next_op     = '0;
          next_cstate = TAS_C_ISSUE;
        end
      end
      TAS_C_ISSUE: begin
        next_ar_start = 1'b1;
        next_cstate   = TAS_C_WAIT;
      end
      TAS_C_WAIT: begin
        if (ar_done) begin
          case (op)
            3'h0:    next_mean     = sum[39] ? -ar_q[23:0] : ar_q[23:0];
            3'h1:    next_var_pop  = ar_q;
            3'h2:    next_var_samp = ar_q;
            3'h3:    next_sd_pop   = ar_q[31:0];
            3'h4:    next_sd_samp  = ar_q[31:0];
            3'h5:    next_var_samp = 64'(q_clamp);
            default: begin
              next_cp  = 16'(var_samp);
              next_cpk = q_clamp;
            end
          endcase
          next_op     = op + 3'h1;
          next_cstate = (op == TAS_OP_LAST) ? TAS_C_IDLE : TAS_C_ISSUE;
        end
      end
      default: next_cstate = TAS_C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cstate       <= TAS_C_IDLE;
      op           <= '0;
      ar_start     <= 1'b0;
      var_pop      <= '0;
      var_samp     <= '0;
      stat_mean    <= '0;
      stat_sd_pop  <= '0;
      stat_sd_samp <= '0;
      stat_cp      <= '0;
      stat_cpk     <= '0;
    end else begin
      cstate       <= next_cstate;
      op           <= next_op;
      ar_start     <= next_ar_start;
      var_pop      <= next_var_pop;
      var_samp     <= next_var_samp;
      stat_mean    <= next_mean;
      stat_sd_pop  <= next_sd_pop;
      stat_sd_samp <= next_sd_samp;
      stat_cp      <= next_cp;
      stat_cpk     <= next_cpk;
    end
  end

  tas_seq_arith u_arith (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (ar_start),
    .op_sqrt  (ar_sqrt),
    .a        (ar_a),
    .b        (ar_b),
    .busy     (),
    .done     (ar_done),
    .q        (ar_q)
  );

endmodule : tas_core

//--- shared/tas_pkg.sv
/*
  Constants, reset values and state encodings for the trigger, averaging
  and statistics block. Assumes a single 100 MHz instrument clock.
*/
package tas_pkg;

  localparam int unsigned TAS_CLK_PERIOD_NS = 10;
  localparam int unsigned TAS_DELAY_STEP_NS = 1000000;
  localparam int unsigned TAS_MS_CYCLES     = (TAS_DELAY_STEP_NS + TAS_CLK_PERIOD_NS - 1)
                                              / TAS_CLK_PERIOD_NS;

  localparam int          TAS_SW            = 24;
  localparam logic [13:0] TAS_DELAY_MAX     = 14'h270F;
  localparam logic [4:0]  TAS_AVG_MIN       = 5'h02;
  localparam logic [4:0]  TAS_AVG_MAX       = 5'h10;
  localparam logic [4:0]  TAS_AVG_OFF       = 5'h01;
  localparam logic [14:0] TAS_STAT_MAX_N    = 15'h7530;
  localparam logic [15:0] TAS_CP_MAX        = 16'h270F;
  localparam logic [6:0]  TAS_CP_SCALE      = 7'h64;
  localparam logic [2:0]  TAS_SIX           = 3'h6;
  localparam logic [2:0]  TAS_OP_LAST       = 3'h6;
  localparam logic [6:0]  TAS_DIV_STEPS     = 7'h40;
  localparam logic [6:0]  TAS_SQRT_STEPS    = 7'h20;
  localparam logic [1:0]  TAS_SYNC_RST      = 2'h3;

  typedef enum logic [2:0] {
    TAS_M_IDLE   = 3'b001,
    TAS_M_DELAY  = 3'b010,
    TAS_M_SAMPLE = 3'b100
  } tas_meas_e;

  typedef enum logic [2:0] {
    TAS_C_IDLE  = 3'b001,
    TAS_C_ISSUE = 3'b010,
    TAS_C_WAIT  = 3'b100
  } tas_calc_e;

  typedef enum logic [1:0] {
    TAS_A_IDLE = 2'b01,
    TAS_A_RUN  = 2'b10
  } tas_arith_e;

endpackage : tas_pkg

//--- hw/tas_seq_arith.sv
/*
  Sequential arithmetic engine: restoring divide of a 64-bit dividend by a
  40-bit divisor (64 steps) or integer square root of a 64-bit value
  (32 steps). Assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ns
module tas_seq_arith
  import tas_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic        op_sqrt,
  input  wire logic [63:0] a,
  input  wire logic [39:0] b,
  output logic             busy,
  output logic             done,
  output logic [63:0]      q
);

  tas_arith_e  state;
  tas_arith_e  next_state;
  logic        op;
  logic        next_op;
  logic [6:0]  cnt;
  logic [6:0]  next_cnt;
  logic [63:0] a_sh;
  logic [63:0] next_a_sh;
  logic [39:0] b_r;
  logic [39:0] next_b_r;
  logic [41:0] rem;
  logic [41:0] next_rem;
  logic [63:0] next_q;
  logic        next_done;

  assign busy = (state == TAS_A_RUN);

  always_comb begin
    logic [41:0] rem_sh;
    logic [41:0] trial;
    logic        ge;
    rem_sh     = op ? {rem[39:0], a_sh[63:62]} : {rem[40:0], a_sh[63]};
    trial      = op ? {8'h00, q[31:0], 2'b01} : {2'b00, b_r};
    ge         = (rem_sh >= trial);
    next_state = state;
    next_op    = op;
    next_cnt   = cnt;
    next_a_sh  = a_sh;
    next_b_r   = b_r;
    next_rem   = rem;
    next_q     = q;
    next_done  = 1'b0;
    case (state)
      TAS_A_IDLE: begin
        if (start) begin
          next_op    = op_sqrt;
          next_a_sh  = a;
          next_b_r   = b;
          next_rem   = '0;
          next_q     = '0;
          next_cnt   = op_sqrt ? TAS_SQRT_STEPS : TAS_DIV_STEPS;
          next_state = TAS_A_RUN;
        end
      end
      TAS_A_RUN: begin
        next_rem  = ge ? rem_sh - trial : rem_sh;
        next_q    = {q[62:0], ge};
        next_a_sh = op ? {a_sh[61:0], 2'b00} : {a_sh[62:0], 1'b0};
        next_cnt  = cnt - 7'h01;
        if (cnt == 7'h01) begin
          next_done  = 1'b1;
          next_state = TAS_A_IDLE;
        end
      end
      default: next_state = TAS_A_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= TAS_A_IDLE;
      op    <= 1'b0;
      cnt   <= '0;
      a_sh  <= '0;
      b_r   <= '0;
      rem   <= '0;
      q     <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      op    <= next_op;
      cnt   <= next_cnt;
      a_sh  <= next_a_sh;
      b_r   <= next_b_r;
      rem   <= next_rem;
      q     <= next_q;
      done  <= next_done;
    end
  end

endmodule : tas_seq_arith

//--- dv/tas_fe_model.sv
/* Front end model: answers each meas_start with one sample two cycles on.
   Assumes the bench supplies the next sample value on val. */
`timescale 1ns/1ns
module tas_fe_model
  import tas_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               meas_start,
  input  wire logic signed [23:0] val,
  output logic                    sample_valid,
  output logic signed [23:0]      sample_data
);
  logic pend = 1'b0;
  // Data outside a sample toggles so it is never mistaken for valid
  always @(posedge core_clk) begin
    pend <= meas_start;
    sample_valid <= pend;
    sample_data <= pend ? val : ~sample_data;
  end
endmodule : tas_fe_model

//--- dv/tas_core_chk.sv
/* Port checker for tas_core.
   Assumes it is bound to tas_core and sees only its ports. */
`timescale 1ns/1ns
module tas_core_chk
  import tas_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TAS_MS_CYCLES
)
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        trig_source_ext,
  input wire logic        continuous_en,
  input wire logic        host_trig,
  input wire logic [13:0] delay_ms,
  input wire logic        sample_valid,
  input wire logic        stat_en,
  input wire logic        settings_changed,
  input wire logic        print_req,
  input wire logic        meas_start,
  input wire logic        result_valid,
  input wire logic [14:0] stat_count,
  input wire logic [15:0] stat_cp,
  input wire logic [15:0] stat_cpk,
  input wire logic        stat_sd_samp_valid,
  input wire logic        stat_cp_valid,
  input wire logic        print_start
);
  logic busy_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Measurement in flight from host trigger or start until its result
  always_ff @(posedge core_clk) begin
    if (srst || result_valid) begin
      busy_q <= 1'b0;
    end else if (meas_start || host_trig) begin
      busy_q <= 1'b1;
    end
  end
  AST_START0: assert property (!busy_q && trig_source_ext && host_trig && delay_ms == 14'h0000
    |=> meas_start) else $error("no start after host trigger");
  AST_NO_FREE: assert property (!trig_source_ext && !continuous_en && !busy_q && !host_trig
    |=> !meas_start) else $error("start without host trigger");
  AST_RES_AFTER: assert property (result_valid |-> $past(sample_valid))
    else $error("result not after a sample");
  AST_COUNT_MAX: assert property (stat_count <= TAS_STAT_MAX_N)
    else $error("count above limit");
  AST_SD_VALID: assert property (stat_count < 15'h0002 && $past(stat_count) < 15'h0002
    |-> !stat_sd_samp_valid) else $error("deviation shown for one sample");
  AST_CP_VALID: assert property (stat_cp_valid |-> stat_sd_samp_valid)
    else $error("index shown for one sample");
  AST_CP_CAP: assert property (stat_cp <= TAS_CP_MAX && stat_cpk <= TAS_CP_MAX)
    else $error("index above cap");
  AST_CPK_LE: assert property (stat_cpk <= stat_cp)
    else $error("bias index above dispersion index");
  AST_DIRTY: assert property (stat_en && settings_changed |=> !stat_cp_valid)
    else $error("index valid after setting change");
  AST_PRINT: assert property (print_req && stat_en |=> print_start)
    else $error("print not started");
  AST_PRINT_ONLY: assert property (print_start |-> $past(print_req) && $past(stat_en))
    else $error("print started unasked");
endmodule : tas_core_chk

bind tas_core tas_core_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.core_clk, .srst, .trig_source_ext,
  .continuous_en, .host_trig, .delay_ms, .sample_valid, .stat_en, .settings_changed, .print_req,
  .meas_start, .result_valid, .stat_count, .stat_cp, .stat_cpk, .stat_sd_samp_valid,
  .stat_cp_valid, .print_start);

//--- dv/tas_tb.sv
/* Self-checking bench for tas_core with a front end model.
   Assumes MS_CYCLES shortened to 4 and a 100 MHz clock. */
`timescale 1ns/1ns
module tb;
  import tas_pkg::*;
  localparam int MSC = 4;
  logic               core_clk, srst, trig_source_ext, continuous_en, key_trig_n, rnd;
  logic               avg_en, stat_en, auto_clear_print, sample_valid, meas_start, iso_trig_n;
  logic               result_valid, stat_sd_samp_valid, stat_cp_valid, print_start;
  logic [4:0]         pl, avg_count;
  logic [13:0]        delay_ms;
  logic [14:0]        stat_count;
  logic [15:0]        stat_cp, stat_cpk;
  logic signed [23:0] sample_data, result_data, stat_mean, stat_max, stat_min, val, fv, step;
  logic [31:0]        seed;
  int                 error_cnt, num_checks, acc, na, n_st, mx, mn, rv, cyc, k, nres;
  longint             s_st;

  tas_core #(.MS_CYCLES(MSC)) dut_u (.core_clk, .srst, .trig_source_ext, .continuous_en,
    .key_trig_n, .iso_trig_n, .host_trig(pl[0]), .delay_ms, .avg_en, .avg_count,
    .sample_valid, .sample_data, .stat_en, .stat_clear(pl[1]), .auto_clear_print,
    .settings_changed(pl[2]), .print_req(pl[3]), .print_done(pl[4]), .thr_hi(24'h00_0064),
    .thr_lo(24'h00_0000), .external_source_indicator(), .meas_start, .result_valid,
    .result_data, .stat_count, .stat_mean, .stat_max, .stat_min, .stat_sd_pop(),
    .stat_sd_samp(), .stat_cp, .stat_cpk, .stat_sd_samp_valid, .stat_cp_valid, .print_start);
  tas_fe_model fe_u (.core_clk, .meas_start, .val, .sample_valid, .sample_data);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("FAIL %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : chk

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic pulse(input int b);
    pl[b] <= 1'b1;
    @(posedge core_clk);
    pl[b] <= 1'b0;
    @(posedge core_clk);
  endtask : pulse

  task automatic wres();
    for (int i = 0; i < 200 && result_valid !== 1'b1; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask : wres

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Sample source, reference averaging and statistics, hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (meas_start) begin
      seed = xs(seed);
      val <= rnd ? 24'($signed(seed[15:0])) : fv;
      fv <= fv + step;
    end
    if (sample_valid) begin
      acc += sample_data;
      na++;
    end
    if (result_valid) begin
      rv = acc / na;
      nres++;
      chk("result_data", rv, result_data);
      chk("samples", avg_en ? avg_count : 1, na);
      if (stat_en && trig_source_ext) begin
        n_st++;
        s_st += rv;
        if (n_st == 1 || rv > mx) mx = rv;
        if (n_st == 1 || rv < mn) mn = rv;
      end
      acc = 0;
      na = 0;
    end
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {srst, trig_source_ext, avg_en, stat_en, auto_clear_print, rnd} = 6'b11_1111;
    {continuous_en, key_trig_n, iso_trig_n, pl, delay_ms} = {3'b111, 5'h00, 14'h0000};
    {avg_count, seed, fv, step, val} = {5'h02, 32'h0000_B6AC, 72'h0};
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("stat_count", 0, stat_count);
    for (k = 0; k < 4; k++) begin
      avg_count <= k < 2 ? 5'h02 : 5'h10;
      pulse(0);
      wres();
    end
    repeat (900) @(posedge core_clk);
    chk("stat_count", n_st, stat_count);
    chk("stat_mean", 32'(s_st / n_st), stat_mean);
    chk("stat_max", mx, stat_max);
    chk("stat_min", mn, stat_min);
    chk("sd_valid", 1, stat_sd_samp_valid);
    chk("cp_valid", 1, stat_cp_valid);
    pulse(2);
    chk("cp_valid", 0, stat_cp_valid);
    pulse(3);
    chk("print_start", 1, print_start);
    pulse(4);
    repeat (3) @(posedge core_clk);
    chk("stat_count", 0, stat_count);
    n_st = 0;
    {avg_en, rnd, fv, step} <= {2'b00, 24'h00_0032, 24'h00_0000};
    delay_ms <= 14'h0002;
    pl[0] <= 1'b1;
    @(posedge core_clk);
    pl[0] <= 1'b0;
    for (k = 1; k < 50 && meas_start !== 1'b1; k++) @(posedge core_clk);
    chk("delay", 2 * MSC + 2, k);
    wres();
    repeat (900) @(posedge core_clk);
    chk("sd_valid", 0, stat_sd_samp_valid);
    chk("cp_valid", 0, stat_cp_valid);
    delay_ms <= 14'h0000;
    pulse(0);
    wres();
    repeat (900) @(posedge core_clk);
    chk("stat_cp", TAS_CP_MAX, stat_cp);
    chk("stat_cpk", TAS_CP_MAX, stat_cpk);
    pulse(1);
    n_st = 0;
    {fv, step} <= {24'h00_03E8, 24'h00_0002};
    for (k = 0; k < 2; k++) begin
      pulse(0);
      wres();
    end
    repeat (900) @(posedge core_clk);
    chk("stat_cpk", 0, stat_cpk);
    chk("stat_max", mx, stat_max);
    {trig_source_ext, rnd} <= 2'b01;
    nres = 0;
    repeat (100) @(posedge core_clk);
    chk("free_run", 1, nres > 5);
    k = stat_count;
    key_trig_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    key_trig_n <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk("grab", k + 1, stat_count);
    continuous_en <= 1'b0;
    repeat (20) @(posedge core_clk);
    nres = 0;
    iso_trig_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    iso_trig_n <= 1'b1;
    repeat (44) @(posedge core_clk);
    chk("no_free_run", 0, nres);
    pulse(0);
    repeat (20) @(posedge core_clk);
    chk("host_only", 1, nres);
    close_out();
  end
endmodule : tb
